// ---- design/e1_tx_bp_pkg.sv ----
package e1_tx_bp_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS       = 50;
    localparam int FRAME_NS     = 125000;  // one E1 frame
    localparam int LINK_KBPS    = 2048;
    localparam int MUX_KBPS     = 8192;
    localparam int FRAME_BITS   = FRAME_NS / 1000 * LINK_KBPS / 1000;
    localparam int MFRAME_BITS  = FRAME_NS / 1000 * MUX_KBPS / 1000;
    localparam int LINK_BIT_NS  = 1000000 / LINK_KBPS;
    // half period of a generated bit clock, rounded down, at least 1
    localparam int HALF_RAW     = (LINK_BIT_NS / 2) / CLK_NS;
    localparam int HALF_CYC     = (HALF_RAW < 1) ? 1 : HALF_RAW;
    localparam int DBL_HALF_CYC = (HALF_CYC / 2 < 1) ? 1 : HALF_CYC / 2;
    localparam int MF_FRAMES    = 16;       // frames per multiframe
    localparam int SAMPLE_DLY   = 3;        // master round trip, cycles

    // ------------------------------------------------------------
    // framing layout
    // ------------------------------------------------------------
    localparam int            NUM_LINKS = 4;
    localparam logic [9:0]    LINK_MASK = 10'(FRAME_BITS - 1);
    localparam logic [9:0]    MUX_MASK  = 10'(MFRAME_BITS - 1);
    localparam logic [6:0]    TSOFF_NONMUX_MASK = 7'h1F;

    // ------------------------------------------------------------
    // system-end registers (APB, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0]  REG_CTRL   = 8'h00;
    localparam logic [7:0]  REG_SEED   = 8'h04;
    localparam logic [7:0]  REG_STATUS = 8'h08;
    localparam int          CTRL_GEN   = 0;   // system makes clock
    localparam int          CTRL_MUX   = 1;   // drive muxed bus
    localparam int          CTRL_INV   = 2;   // frame pulse active low
    localparam int          CTRL_DBL   = 3;   // double-rate clock
    localparam int          CTRL_LRISE = 4;   // launch on rising edge
    localparam logic [4:0]  CTRL_RST   = 5'h00;
    localparam logic [7:0]  SEED_RST   = 8'h00;

    typedef enum {MODE_MASTER, MODE_SLAVE, MODE_MUX} link_mode_t;

endpackage

// ---- design/e1_bp_if.sv ----
interface e1_bp_if;

    // per-link system data, system drives
    logic [3:0] link_tx_serial_in;
    logic [3:0] link_signaling_in;
    // per-link two-way clock and frame pulse, one driver set per end
    logic [3:0] dev_clk_o;
    logic [3:0] dev_clk_oe_n;
    logic [3:0] sys_clk_o;
    logic [3:0] sys_clk_oe_n;
    logic [3:0] dev_fp_o;
    logic [3:0] dev_fp_oe_n;
    logic [3:0] sys_fp_o;
    logic [3:0] sys_fp_oe_n;
    logic [3:0] link_bit_clock;
    logic [3:0] link_frame_pulse;
    // multiplexed bus, system drives
    logic       muxed_bit_clock;
    logic       muxed_frame_pulse;
    logic       bus_select_or_data_a;
    logic       muxed_data_in_b;
    logic       muxed_signaling_a;
    logic       muxed_signaling_b;

    // wire level: undriven reads low
    assign link_bit_clock   = (~dev_clk_oe_n & dev_clk_o)
                            | (~sys_clk_oe_n & sys_clk_o);
    assign link_frame_pulse = (~dev_fp_oe_n & dev_fp_o)
                            | (~sys_fp_oe_n & sys_fp_o);

    modport device (
        input  link_tx_serial_in, link_signaling_in,
        input  link_bit_clock, link_frame_pulse,
        input  muxed_bit_clock, muxed_frame_pulse,
        input  bus_select_or_data_a, muxed_data_in_b,
        input  muxed_signaling_a, muxed_signaling_b,
        output dev_clk_o, dev_clk_oe_n, dev_fp_o, dev_fp_oe_n
    );

    modport system (
        output link_tx_serial_in, link_signaling_in,
        output sys_clk_o, sys_clk_oe_n, sys_fp_o, sys_fp_oe_n,
        output muxed_bit_clock, muxed_frame_pulse,
        output bus_select_or_data_a, muxed_data_in_b,
        output muxed_signaling_a, muxed_signaling_b,
        input  link_bit_clock, link_frame_pulse
    );

endinterface

// ---- design/e1_tx_bp_system.sv ----
module e1_tx_bp_system (
    // clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RSTN_I,
    // apb slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    // backplane
    e1_bp_if.system          bp
);

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [4:0]  ctrl_r;
    logic [7:0]  seed_r;
    logic [15:0] frames_r;
    logic [31:0] rdata_r;
    logic        rdy_r;
    logic        err_r;

    wire acc  = PSEL_I & PENABLE_I;
    wire hit  = (PADDR_I == e1_tx_bp_pkg::REG_CTRL)
              | (PADDR_I == e1_tx_bp_pkg::REG_SEED)
              | (PADDR_I == e1_tx_bp_pkg::REG_STATUS);
    wire [31:0] rd_val =
        (PADDR_I == e1_tx_bp_pkg::REG_CTRL) ? {27'h0, ctrl_r} :
        (PADDR_I == e1_tx_bp_pkg::REG_SEED) ? {24'h0, seed_r} :
        (PADDR_I == e1_tx_bp_pkg::REG_STATUS) ? {16'h0, frames_r} :
        32'h0;
    wire wr   = acc & rdy_r & PWRITE_I;

    // one wait state: read data always comes from a flop
    always_ff @(posedge CLK_I)
    begin
        if (!RSTN_I)
        begin
            rdy_r   <= 1'b0;
            err_r   <= 1'b0;
            rdata_r <= 32'h0;
            ctrl_r  <= e1_tx_bp_pkg::CTRL_RST;
            seed_r  <= e1_tx_bp_pkg::SEED_RST;
        end
        else
        begin
            rdy_r <= acc & ~rdy_r;
            if (acc & ~rdy_r)
            begin
                rdata_r <= rd_val;
                err_r   <= ~hit;
            end
            if (wr && PADDR_I == e1_tx_bp_pkg::REG_CTRL)
                ctrl_r <= PWDATA_I[4:0];
            if (wr && PADDR_I == e1_tx_bp_pkg::REG_SEED)
                seed_r <= PWDATA_I[7:0];
        end
    end

    assign PREADY_O  = rdy_r;
    assign PSLVERR_O = rdy_r & err_r;
    assign PRDATA_O  = rdata_r;

    // ------------------------------------------------------------
    // bit timing: own divider, or follow the device clock
    // ------------------------------------------------------------
    wire gen   = ctrl_r[e1_tx_bp_pkg::CTRL_GEN];
    wire mux   = ctrl_r[e1_tx_bp_pkg::CTRL_MUX];
    wire inv   = ctrl_r[e1_tx_bp_pkg::CTRL_INV];
    wire dbl   = ctrl_r[e1_tx_bp_pkg::CTRL_DBL];
    wire lrise = ctrl_r[e1_tx_bp_pkg::CTRL_LRISE];

    logic [7:0] div_r;
    logic       gclk_r;
    logic [2:0] c_s1_r, c_s2_r;   // {clk, fp} sync, then previous
    logic       c_s3_r;
    logic       fpprev_r;
    logic       lph_r;
    logic [9:0] hbit_r;

    wire [7:0] half = dbl ? 8'(e1_tx_bp_pkg::DBL_HALF_CYC)
                          : 8'(e1_tx_bp_pkg::HALF_CYC);
    // >= so a switch to double rate mid-count cannot stall the clock
    wire wrap  = (div_r >= half - 8'h01);
    wire rise  = gen ? (wrap & ~gclk_r) : (c_s2_r[1] & ~c_s3_r);
    wire fall  = gen ? (wrap & gclk_r) : (~c_s2_r[1] & c_s3_r);
    wire l_ev  = lrise ? rise : fall;
    // the device pulse is new when it was idle at the last launch edge
    wire fpact  = c_s2_r[0] ^ inv;
    wire fp_new = ~gen & l_ev & fpact & ~fpprev_r;
    wire launch = l_ev & (~gen | ~dbl | ~lph_r);
    wire [9:0] idx  = fp_new ? 10'h000 : hbit_r;
    wire [9:0] mask = mux ? e1_tx_bp_pkg::MUX_MASK
                          : e1_tx_bp_pkg::LINK_MASK;

    always_ff @(posedge CLK_I)
    begin
        if (!RSTN_I)
        begin
            div_r    <= 8'h00;
            gclk_r   <= 1'b0;
            c_s1_r   <= 3'h0;
            c_s2_r   <= 3'h0;
            c_s3_r   <= 1'b0;
            fpprev_r <= 1'b0;
            lph_r    <= 1'b0;
            hbit_r   <= 10'h000;
        end
        else
        begin
            div_r  <= wrap ? 8'h00 : div_r + 8'h01;
            if (wrap)
                gclk_r <= ~gclk_r;
            c_s1_r <= {1'b0, bp.link_bit_clock[0], bp.link_frame_pulse[0]};
            c_s2_r <= c_s1_r;
            c_s3_r <= c_s2_r[1];
            if (l_ev)
            begin
                fpprev_r <= fpact;
                lph_r    <= ~lph_r;
            end
            if (launch)
                hbit_r <= (idx + 10'h001) & mask;
        end
    end

    // ------------------------------------------------------------
    // payload: seed xor position, signaling its complement
    // ------------------------------------------------------------
    logic [3:0] dat_r;
    logic       mdat_r;
    logic       fp_r;

    wire [2:0] bsel  = ~idx[2:0];      // msb first
    wire [7:0] mbyte = seed_r ^ {1'b0, idx[9:3]};

    always_ff @(posedge CLK_I)
    begin
        if (!RSTN_I)
        begin
            dat_r    <= 4'h0;
            mdat_r   <= 1'b0;
            fp_r     <= 1'b0;
            frames_r <= 16'h0000;
        end
        else if (launch)
        begin
            for (int n = 0; n < e1_tx_bp_pkg::NUM_LINKS; n++)
                dat_r[n] <= 1'((seed_r ^ {idx[7:3], 3'(n)}) >> bsel);
            mdat_r <= mbyte[bsel];
            fp_r   <= (idx == 10'h000) ^ inv;
            if (idx == 10'h000)
                frames_r <= frames_r + 16'h0001;
        end
    end

    // pins: link clock pair only when generating in per-link mode
    assign bp.sys_clk_o            = {4{gclk_r}};
    assign bp.sys_fp_o             = {4{fp_r}};
    assign bp.sys_clk_oe_n         = {4{~(gen & ~mux)}};
    assign bp.sys_fp_oe_n          = {4{~(gen & ~mux)}};
    assign bp.link_tx_serial_in    = dat_r;
    assign bp.link_signaling_in    = ~dat_r;
    assign bp.muxed_bit_clock      = gen & mux & gclk_r;
    assign bp.muxed_frame_pulse    = gen & mux & fp_r;
    assign bp.bus_select_or_data_a = mdat_r;
    assign bp.muxed_data_in_b      = mdat_r;
    assign bp.muxed_signaling_a    = ~mdat_r;
    assign bp.muxed_signaling_b    = ~mdat_r;

endmodule

// ---- design/e1_tx_bp_device.sv ----
module e1_tx_bp_device (
    // clock and reset
    input  wire logic         CLK_I,
    input  wire logic         RSTN_I,
    // per-link mode and timing configuration
    input  wire logic [3:0]   TX_MUX_SELECT_I,
    input  wire logic [3:0]   TX_SLAVE_SELECT_I,
    input  wire logic [3:0]   FRAME_EDGE_SELECT_I,
    input  wire logic [3:0]   DATA_EDGE_SELECT_I,
    input  wire logic [3:0]   FRAME_PULSE_KIND_I,
    input  wire logic [3:0]   FRAME_PULSE_POLARITY_I,
    input  wire logic [3:0]   CLOCK_DOUBLE_SELECT_I,
    input  wire logic [3:0]   SECOND_EDGE_SELECT_I,
    input  wire logic [3:0]   BIT8_CLOCK_GAP_I,
    input  wire logic [127:0] TIMESLOT_CLOCK_SKIP_I,
    input  wire logic [11:0]  BIT_OFFSET_I,
    input  wire logic [27:0]  TS_OFFSET_I,
    // global configuration
    input  wire logic         SHARED_SLAVE_CLOCK_I,
    input  wire logic         MUX_BUS_B_SELECT_I,
    // pulse period checking
    input  wire logic [3:0]   PULSE_PERIOD_ERROR_ENABLE_I,
    input  wire logic [3:0]   PULSE_PERIOD_ERROR_CLEAR_I,
    output logic      [3:0]   PULSE_PERIOD_ERROR_FLAG_O,
    output logic              IRQ_N_O,
    // received bytes towards the line side
    output logic      [31:0]  PAYLOAD_BYTE_O,
    output logic      [31:0]  SIGNAL_BYTE_O,
    output logic      [19:0]  TIMESLOT_O,
    output logic      [3:0]   BYTE_VALID_O,
    // backplane
    e1_bp_if.device           bp
);

    // wrap a bit position to the frame length of the mode
    function automatic logic [9:0] wrap_pos(input logic [9:0] v,
                                            input logic       mux);
        wrap_pos = v & (mux ? e1_tx_bp_pkg::MUX_MASK
                            : e1_tx_bp_pkg::LINK_MASK);
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers: s1 feeds s2 only, s3 is s2 one cycle late
    // ------------------------------------------------------------
    logic [21:0] s1_r, s2_r, s3_r;

    wire [21:0] pins = {bp.link_bit_clock, bp.link_frame_pulse,
                        bp.link_tx_serial_in, bp.link_signaling_in,
                        bp.muxed_bit_clock, bp.muxed_frame_pulse,
                        bp.bus_select_or_data_a, bp.muxed_data_in_b,
                        bp.muxed_signaling_a, bp.muxed_signaling_b};

    always_ff @(posedge CLK_I)
    begin
        if (!RSTN_I)
        begin
            s1_r <= 22'h000000;
            s2_r <= 22'h000000;
            s3_r <= 22'h000000;
        end
        else
        begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // ------------------------------------------------------------
    // master bit clock divider, common to all links
    // ------------------------------------------------------------
    logic [7:0] div_r;
    logic       gclk_r;

    wire div_wrap = (div_r == 8'(e1_tx_bp_pkg::HALF_CYC - 1));
    wire g_rise   = div_wrap & ~gclk_r;
    wire g_fall   = div_wrap & gclk_r;

    always_ff @(posedge CLK_I)
    begin
        if (!RSTN_I)
        begin
            div_r  <= 8'h00;
            gclk_r <= 1'b0;
        end
        else
        begin
            div_r <= div_wrap ? 8'h00 : div_r + 8'h01;
            if (div_wrap)
                gclk_r <= ~gclk_r;    // free running
        end
    end

    // link 0 pair is shared only if all four are slaves
    wire [3:0] is_slave = ~TX_MUX_SELECT_I & TX_SLAVE_SELECT_I;
    wire       shared   = SHARED_SLAVE_CLOCK_I & (&is_slave);

    // selected muxed set, a and b are backups of each other
    wire mux_dat = MUX_BUS_B_SELECT_I ? s2_r[2] : s2_r[3];
    wire mux_sig = MUX_BUS_B_SELECT_I ? s2_r[0] : s2_r[1];

    // ------------------------------------------------------------
    // per-link receive logic
    // ------------------------------------------------------------
    for (genvar i = 0; i < e1_tx_bp_pkg::NUM_LINKS; i++)
    begin : g_link
        e1_tx_bp_pkg::link_mode_t mode;
        logic [7:0] mbit_r;
        logic [3:0] mfrm_r;
        logic       mfp_r;
        logic [e1_tx_bp_pkg::SAMPLE_DLY-1:0] dly_r;
        logic       fpprev_r, seen_r, dph_r, err_r, vld_r;
        logic [9:0] pos_r;
        logic [7:0] sh_r, sg_r, byte_r, sbyte_r;
        logic [4:0] ts_r;

        assign mode = TX_MUX_SELECT_I[i] ? e1_tx_bp_pkg::MODE_MUX :
                      TX_SLAVE_SELECT_I[i] ? e1_tx_bp_pkg::MODE_SLAVE :
                      e1_tx_bp_pkg::MODE_MASTER;
        wire master = (mode == e1_tx_bp_pkg::MODE_MASTER);
        wire mux    = (mode == e1_tx_bp_pkg::MODE_MUX);
        wire fe     = FRAME_EDGE_SELECT_I[i];      // 1: rising edge
        wire de     = DATA_EDGE_SELECT_I[i];
        wire pol    = FRAME_PULSE_POLARITY_I[i];   // 1: active low
        wire dbl    = CLOCK_DOUBLE_SELECT_I[i];

        // master: launch edge is the one opposite the sample edge
        wire m_d_ev = de ? g_rise : g_fall;
        wire m_l_ev = de ? g_fall : g_rise;
        wire m_f_ev = fe ? g_rise : g_fall;
        wire m_last = (mbit_r == e1_tx_bp_pkg::LINK_MASK[7:0]);
        wire mf_end = ~FRAME_PULSE_KIND_I[i] |
                      (mfrm_r == 4'(e1_tx_bp_pkg::MF_FRAMES - 1));
        // gapped bit: skipped timeslot or bit 8
        wire gapped = master & (TIMESLOT_CLOCK_SKIP_I[32*i + mbit_r[7:3]]
                      | (BIT8_CLOCK_GAP_I[i] & (&mbit_r[2:0])));

        always_ff @(posedge CLK_I)
        begin
            if (!RSTN_I)
            begin
                mbit_r <= 8'h00;
                mfrm_r <= 4'h0;
                mfp_r  <= 1'b0;
                dly_r  <= '0;
            end
            else
            begin
                if (m_l_ev)
                    mbit_r <= mbit_r + 8'h01;   // 32 timeslots
                if (m_l_ev & m_last)
                    mfrm_r <= mfrm_r + 4'h1;
                if (m_f_ev)
                    mfp_r <= m_last & mf_end;  // pulse ahead of bit 0
                // wait for the system's answer to cross back
                dly_r <= {dly_r[e1_tx_bp_pkg::SAMPLE_DLY-2:0], m_d_ev};
            end
        end

        // clock and pulse go out only in master mode
        assign bp.dev_clk_o[i]    = gclk_r & ~gapped;
        assign bp.dev_clk_oe_n[i] = ~master;
        assign bp.dev_fp_o[i]     = mfp_r ^ pol;
        assign bp.dev_fp_oe_n[i]  = ~master;

        // slave or muxed: edges of the system clock
        wire src  = shared ? 1'b0 : 1'b1;
        wire c2   = mux ? s2_r[5] : (src ? s2_r[18+i] : s2_r[18]);
        wire c3   = mux ? s3_r[5] : (src ? s3_r[18+i] : s3_r[18]);
        wire fpin = mux ? s2_r[4] : (src ? s2_r[14+i] : s2_r[14]);
        wire din  = mux ? mux_dat : s2_r[10+i];
        wire sin  = mux ? mux_sig : s2_r[6+i];
        wire rise = c2 & ~c3;
        wire fall = ~c2 & c3;
        wire d_ev = ~master & (de ? rise : fall);
        wire f_ev = ~master & (fe ? rise : fall);
        wire fpact  = fpin ^ pol;
        // only the first active edge of a pulse counts
        wire fp_new = f_ev & fpact & ~fpprev_r;
        wire same   = fp_new & d_ev;
        wire cur_ph = same ? 1'b0 : dph_r;
        // double rate: pick the first or second edge of each bit
        wire s_take = d_ev & (~dbl | (cur_ph == SECOND_EDGE_SELECT_I[i]));
        wire take   = master ? (dly_r[e1_tx_bp_pkg::SAMPLE_DLY-1]
                                & ~gapped) : s_take;
        wire [9:0] idx = master ? {2'b00, mbit_r} :
                         (same ? 10'h000 : pos_r);
        // pulse spacing must be whole frames
        wire set_err = fp_new & seen_r & (pos_r != 10'h000);

        // offset in bits; counting bits doubles it in clocks
        wire [6:0] tso  = mux ? TS_OFFSET_I[7*i +: 7]
                   : TS_OFFSET_I[7*i +: 7] & e1_tx_bp_pkg::TSOFF_NONMUX_MASK;
        wire [9:0] off  = {tso, 3'b000} + {7'h00, BIT_OFFSET_I[3*i +: 3]};
        wire [9:0] didx = wrap_pos(idx - off, mux);
        // muxed: this link owns one byte of every four
        wire lane = ~mux | (didx[4:3] == 2'b00);
        wire eob  = master ? (dly_r[e1_tx_bp_pkg::SAMPLE_DLY-1]
                              & (&didx[2:0])) : (take & (&didx[2:0]));

        always_ff @(posedge CLK_I)
        begin
            if (!RSTN_I)
            begin
                fpprev_r <= 1'b0;
                seen_r   <= 1'b0;
                dph_r    <= 1'b0;
                pos_r    <= 10'h000;
                err_r    <= 1'b0;
                sh_r     <= 8'h00;
                sg_r     <= 8'h00;
                byte_r   <= 8'h00;
                sbyte_r  <= 8'h00;
                ts_r     <= 5'h00;
                vld_r    <= 1'b0;
            end
            else
            begin
                if (f_ev)
                    fpprev_r <= fpact;
                if (d_ev)
                    dph_r <= ~cur_ph;
                else if (fp_new)
                    dph_r <= 1'b0;
                if (master)
                    seen_r <= 1'b0;
                else if (fp_new)
                    seen_r <= 1'b1;
                if (s_take)
                    pos_r <= wrap_pos(idx + 10'h001, mux);
                else if (fp_new)
                    pos_r <= 10'h000;
                // a new error beats a clear in the same cycle
                err_r <= set_err | (err_r & ~PULSE_PERIOD_ERROR_CLEAR_I[i]);
                // gapped bits are skipped, or enter as zero at a byte end: their data is don't care
                if (take | eob)
                begin
                    sh_r <= {sh_r[6:0], din & take};
                    sg_r <= {sg_r[6:0], sin & take};
                end
                vld_r <= eob & lane;
                if (eob & lane)
                begin
                    byte_r  <= {sh_r[6:0], din & take};
                    sbyte_r <= {sg_r[6:0], sin & take};
                    ts_r    <= mux ? didx[9:5] : didx[7:3];
                end
            end
        end

        assign PAYLOAD_BYTE_O[8*i +: 8]    = byte_r;
        assign SIGNAL_BYTE_O[8*i +: 8]     = sbyte_r;
        assign TIMESLOT_O[5*i +: 5]        = ts_r;
        assign BYTE_VALID_O[i]             = vld_r;
        assign PULSE_PERIOD_ERROR_FLAG_O[i] = err_r;
    end

    // interrupt when any enabled error flag is set
    assign IRQ_N_O = ~|(PULSE_PERIOD_ERROR_FLAG_O
                        & PULSE_PERIOD_ERROR_ENABLE_I);

endmodule

// ---- test/e1_tx_bp_monitor.sv ----
module e1_tx_bp_monitor (
    // clock, reset
    input wire logic       CLK_I,
    input wire logic       RSTN_I,
    // backplane wires
    input wire logic [3:0] dev_clk_oe_n,
    input wire logic [3:0] sys_clk_oe_n,
    input wire logic [3:0] link_bit_clock,
    input wire logic [3:0] link_tx_serial_in,
    input wire logic [3:0] link_signaling_in,
    input wire logic       muxed_bit_clock,
    input wire logic       bus_select_or_data_a,
    input wire logic       muxed_data_in_b,
    input wire logic       muxed_signaling_a
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // wire rules on the block clock
    // ----------------------------------------
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    // two ends driving one clock wire would fight
    chk_one_clk_drv:
        assert property ((~dev_clk_oe_n & ~sys_clk_oe_n) == 4'h0)
        else $error("clock wire has two drivers");
    chk_sig_follow:
        assert property ($changed(link_tx_serial_in) |->
        link_signaling_in == ~link_tx_serial_in) else $error("sig skew");
    chk_mux_sig_a:
        assert property ($changed(bus_select_or_data_a) |->
        muxed_signaling_a != bus_select_or_data_a) else $error("mux sig");
    chk_mux_sets_eq:
        assert property ($changed(bus_select_or_data_a) |->
        muxed_data_in_b == bus_select_or_data_a) else $error("set b");
    // generated clock: high phase and full bit period
    chk_dev_clk_high:
        assert property ($rose(link_bit_clock[0]) && !dev_clk_oe_n[0]
        |-> ##[1:4] !link_bit_clock[0]) else $error("master high");
    // a rise at the hand-over into master mode may start a short high
    chk_dev_clk_rate:
        assert property ($rose(link_bit_clock[0]) && !dev_clk_oe_n[0]
        && !$past(dev_clk_oe_n[0])
        |=> !$rose(link_bit_clock[0]) [*7]) else $error("master rate");
    chk_sys_clk_high:
        assert property ($rose(link_bit_clock[1]) && !sys_clk_oe_n[1]
        |-> ##[1:4] !link_bit_clock[1]) else $error("slave high");
    chk_mux_clk_high:
        assert property ($rose(muxed_bit_clock) |-> ##[1:4]
        !muxed_bit_clock) else $error("mux clock high");
endmodule

// ---- test/e1_tx_backplane_interface_tb_top.sv ----
module e1_tx_backplane_interface_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0;
    logic        pwr = 1'b0, bsel = 1'b0, pready, perr, irq_n;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwd = 32'h0, prd, pay, sig;
    logic [3:0]  mux = 4'h0, slv = 4'h0, de = 4'h0, dbl = 4'h0, pol = 4'h0;
    logic [3:0]  en = 4'h0, clr = 4'h0, fe = 4'h0, flag, vld;
    logic [27:0] toff = 28'h0;
    logic [19:0] tsl;
    int          err_total = 0, samples_checked = 0;
    e1_bp_if     bp ();
    // ----------------------------------------
    // both ends, checker and scenarios
    // ----------------------------------------
    e1_tx_bp_system u_e1_tx_bp_system (.CLK_I(clk), .RSTN_I(rstn),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
        .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(pready),
        .PSLVERR_O(perr), .bp(bp.system));
    e1_tx_bp_device u_e1_tx_bp_device (.CLK_I(clk), .RSTN_I(rstn),
        .TX_MUX_SELECT_I(mux), .TX_SLAVE_SELECT_I(slv),
        .FRAME_EDGE_SELECT_I(fe), .DATA_EDGE_SELECT_I(de),
        .FRAME_PULSE_KIND_I(4'h0), .FRAME_PULSE_POLARITY_I(pol),
        .CLOCK_DOUBLE_SELECT_I(dbl), .SECOND_EDGE_SELECT_I(dbl),
        .BIT8_CLOCK_GAP_I(4'h0), .TIMESLOT_CLOCK_SKIP_I(128'h0),
        .BIT_OFFSET_I(12'h000), .TS_OFFSET_I(toff),
        .SHARED_SLAVE_CLOCK_I(1'b0), .MUX_BUS_B_SELECT_I(bsel),
        .PULSE_PERIOD_ERROR_ENABLE_I(en), .PULSE_PERIOD_ERROR_CLEAR_I(clr),
        .PULSE_PERIOD_ERROR_FLAG_O(flag), .IRQ_N_O(irq_n),
        .PAYLOAD_BYTE_O(pay), .SIGNAL_BYTE_O(sig), .TIMESLOT_O(tsl),
        .BYTE_VALID_O(vld), .bp(bp.device));
    e1_tx_bp_monitor u_e1_tx_bp_monitor (.CLK_I(clk), .RSTN_I(rstn),
        .dev_clk_oe_n(bp.dev_clk_oe_n), .sys_clk_oe_n(bp.sys_clk_oe_n),
        .link_bit_clock(bp.link_bit_clock),
        .link_tx_serial_in(bp.link_tx_serial_in),
        .link_signaling_in(bp.link_signaling_in),
        .muxed_bit_clock(bp.muxed_bit_clock),
        .bus_select_or_data_a(bp.bus_select_or_data_a),
        .muxed_data_in_b(bp.muxed_data_in_b),
        .muxed_signaling_a(bp.muxed_signaling_a));
    // block clock, 50 ns period
    always #25 clk = ~clk;
    task automatic chk(input logic [15:0] g, input logic [15:0] x);
        samples_checked++;
        if (g !== x)
        begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    // apb master: holds the request until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1; pwr <= w; paddr <= a; pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do @(posedge clk); while (pready !== 1'b1);
        q = prd; e = perr;
        psel <= 1'b0; pen <= 1'b0;
    endtask
    // system released first so the clock wires never see two drivers
    task automatic run(input logic [5:0] c);
        logic [31:0] q; logic [7:0] x; logic e; int n;
        n = 0;
        apb(1'b1, 8'h00, 32'h0, q, e);
        slv <= {4{c[0] & ~c[1]}}; mux <= {4{c[1]}}; de <= {4{~c[4]}};
        fe <= {4{~c[4] | (c[2] & ~c[1])}};
        dbl <= {4{c[3]}}; pol <= {4{c[2]}}; bsel <= c[5];
        toff <= c[1] ? 28'h0608080 : 28'h0000000;
        apb(1'b1, 8'h04, 32'h5A, q, e);
        apb(1'b1, 8'h00, {27'h0, c[4:0]}, q, e);
        // muxed frames are four times longer: wait for a pulse first
        repeat (c[1] ? 8400 : 4400) @(posedge clk);
        repeat (8000)
        begin
            @(posedge clk);
            #1;
            for (int k = 0; k < 4; k++)
                if ((c[0] || k == 0) && vld[k] === 1'b1)
                begin
                    x = c[1] ? {1'b0, 7'(4 * tsl[5*k+:5] + k)}
                             : {tsl[5*k+:5], 3'(k)};
                    chk({pay[8*k+:8], sig[8*k+:8]},
                        {x, ~x} ^ 16'h5A5A);
                    n++;
                end
        end
        chk(16'(n > 40), 16'h0001);
        $display("test done ctrl=%h bytes=%0d", c, n);
    endtask
    // a burst at double rate makes the device count extra bits
    task automatic t_err();
        logic [31:0] q; logic e;
        en <= 4'h1;
        apb(1'b1, 8'h00, 32'h19, q, e);
        repeat (700) @(posedge clk);
        apb(1'b1, 8'h00, 32'h11, q, e);
        repeat (4400) @(posedge clk);
        chk({11'h0, irq_n, flag}, 16'h000F);
        en <= 4'h0; clr <= 4'hF;
        @(posedge clk);
        clr <= 4'h0;
        apb(1'b0, 8'h0C, 32'h0, q, e);
        chk({11'h0, irq_n, flag}, 16'h0010);
        chk({15'h0, e}, 16'h0001);
        apb(1'b0, 8'h04, 32'h0, q, e);
        chk(q[15:0], 16'h005A);
        $display("test done pulse spacing");
    endtask
    task automatic complete_run();
        $display("checks=%0d errors=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // a hang is cut short about 5% past the end of the full sequence of runs
    initial
    begin
        #4600000;
        err_total++;
        complete_run();
    end
    // reset for two cycles, then slave, mux and master in turn
    initial
    begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        run(6'h11);
        t_err();
        run(6'h15);
        run(6'h09);
        run(6'h13);
        run(6'h2B);
        run(6'h00);
        complete_run();
    end
endmodule
